/* src/xcd_pkg.sv */
// Purpose: Shared constants for the crystal clock divider and tuning block.
// Assumes: clk_i is the crystal oscillator clock itself.
// Notes: Tuning fields and band encodings are used by the top; the bench imports them but uses literals.
package xcd_pkg;

  // ---------------------------------------------------------------
  // Divider figures
  // ---------------------------------------------------------------
  localparam int unsigned XCD_HOST_DIV = 3;
  localparam int unsigned XCD_DIG_DIV = 16;
  localparam logic [1:0] XCD_HOST_LAST = 2'h2;
  localparam logic [3:0] XCD_DIG_LAST = 4'hf;

  // ---------------------------------------------------------------
  // Field widths
  // ---------------------------------------------------------------
  localparam int unsigned XCD_PART_W = 13;
  localparam int unsigned XCD_WORD_W = 14;
  localparam int unsigned XCD_LIMIT_W = 6;
  localparam int unsigned XCD_BITCNT_W = 9;
  localparam int unsigned XCD_DIVIDER_W = 22;
  localparam int unsigned XCD_SYNC_W = 3;

  // ---------------------------------------------------------------
  // Synchroniser bit positions
  // ---------------------------------------------------------------
  localparam int unsigned XCD_SYNC_XTO = 0;
  localparam int unsigned XCD_SYNC_UPPER = 1;
  localparam int unsigned XCD_SYNC_LOWER = 2;

  // ---------------------------------------------------------------
  // Synthesizer divider, in units of 1/32768
  // ---------------------------------------------------------------
  localparam logic [7:0] XCD_BASE2_LOW = 8'h31;
  localparam logic [7:0] XCD_BASE2_MID = 8'h41;
  localparam logic [7:0] XCD_BASE2_HIGH = 8'h81;
  localparam logic [XCD_DIVIDER_W-1:0] XCD_FRAC_OFFSET2 = 22'h000029;
  localparam int unsigned XCD_FRAC_SHIFT = 14;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] XCD_HOST_CNT_RST = 2'h0;
  localparam logic [3:0] XCD_DIG_CNT_RST = 4'h0;
  localparam logic [XCD_BITCNT_W-1:0] XCD_BITCNT_RST = 9'h000;
  localparam logic [XCD_WORD_W-1:0] XCD_WORD_RST = 14'h0000;
  localparam logic [XCD_DIVIDER_W-1:0] XCD_DIVIDER_RST = 22'h000000;

  typedef enum logic [1:0] {
    XCD_RANGE0,
    XCD_RANGE1,
    XCD_RANGE2,
    XCD_RANGE3
  } xcd_range_type;

endpackage

/* src/xcd_top.sv */
// Purpose: Host clock, digital cycle, bit cycle, tuning word and host reset logic.
// Assumes: clk_i is the oscillator; status pins are asynchronous, config is local.
// Notes: The host clock uses a falling-edge flop to reach half-cycle resolution.
`timescale 1ns/1ps

module xcd_top (
  input wire logic clk_i, // Oscillator clock.
  input wire logic resetn_i, // Asynchronous reset, active low.
  input wire logic xto_ok_i, // Amplitude detector output, asynchronous.
  input wire logic supply_output_upper_ok_i, // Supply above upper threshold.
  input wire logic supply_output_lower_ok_i, // Supply above lower threshold.
  input wire logic host_clk_enable_i, // Host clock enable bit.
  input wire logic idle_mode_i, // Idle operating mode.
  input wire logic sleep_mode_i, // Sleep operating mode.
  input wire logic [1:0] baud_range_select_i, // Baud range 0 to 3.
  input wire logic [xcd_pkg::XCD_LIMIT_W-1:0] bit_limit_factor_i, // Limit factor.
  input wire logic [xcd_pkg::XCD_PART_W-1:0] tuning_part_low_i, // Low tuning part.
  input wire logic [xcd_pkg::XCD_PART_W-1:0] tuning_part_high_i, // High tuning part.
  input wire logic band_select_bit_i, // Band select bit.
  input wire logic band_select_pin_i, // Band pin, high for the lower bands.
  output logic host_clk_o, // Divide-by-three host clock.
  output logic host_reset_n_o, // Host reset, active low.
  output logic digital_cycle_o, // One-cycle pulse every 16 clocks.
  output logic derived_bit_cycle_o, // One-cycle pulse per bit cycle.
  output logic [xcd_pkg::XCD_WORD_W-1:0] tuning_word_o, // Summed tuning word.
  output logic [xcd_pkg::XCD_DIVIDER_W-1:0] synth_divider_o, // Divider times 32768.
  output logic load_cap_reduce_o, // Partial load capacitor disconnect.
  output logic serial_if_enable_o // Serial interface accepted.
);
  import xcd_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [XCD_SYNC_W-1:0] async_in;
  logic [XCD_SYNC_W-1:0] sync1_r;
  logic [XCD_SYNC_W-1:0] sync2_r;
  logic xto_ok_s;
  logic upper_ok_s;
  logic lower_ok_s;

  assign async_in = {supply_output_lower_ok_i, supply_output_upper_ok_i, xto_ok_i};

  genvar gi;
  generate
    for (gi = 0; gi < XCD_SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  assign xto_ok_s = sync2_r[XCD_SYNC_XTO];
  assign upper_ok_s = sync2_r[XCD_SYNC_UPPER];
  assign lower_ok_s = sync2_r[XCD_SYNC_LOWER];

  // ---------------------------------------------------------------
  // Host clock divider
  // ---------------------------------------------------------------
  logic [1:0] host_cnt_r;
  logic [1:0] host_cnt_nxt;
  logic host_run;
  logic host_pos_r;
  logic host_neg_r;

  // The enable is sampled here, so the last high phase can be cut short.
  assign host_run = xto_ok_s && host_clk_enable_i && lower_ok_s;
  assign host_cnt_nxt = (!host_run || host_cnt_r == XCD_HOST_LAST) ?
                        XCD_HOST_CNT_RST : host_cnt_r + 2'h1;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_cnt_r <= XCD_HOST_CNT_RST;
      host_pos_r <= 1'b0;
    end else begin
      host_cnt_r <= host_cnt_nxt;
      host_pos_r <= host_run && (host_cnt_nxt == XCD_HOST_CNT_RST);
    end
  end

  // A half-cycle stretch turns a one-in-three pulse into a 1.5 cycle high phase.
  always_ff @(negedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_neg_r <= 1'b0;
    end else begin
      host_neg_r <= host_pos_r && host_run;
    end
  end

  assign host_clk_o = host_pos_r | host_neg_r;

  // ---------------------------------------------------------------
  // Digital cycle and bit cycle
  // ---------------------------------------------------------------
  logic [3:0] dig_cnt_r;
  logic [XCD_BITCNT_W-1:0] bit_cnt_r;
  logic [XCD_BITCNT_W-1:0] bit_target;
  logic [XCD_LIMIT_W-1:0] limit_eff;
  logic dig_tick;

  // A zero limit factor would give a zero target and fire on every digital cycle, so it is run as one.
  assign limit_eff = (bit_limit_factor_i == '0) ? {{(XCD_LIMIT_W-1){1'b0}}, 1'b1} :
                     bit_limit_factor_i;
  assign bit_target = XCD_BITCNT_W'({3'h0, limit_eff} <<
                      (2'h3 - baud_range_select_i));
  assign dig_tick = xto_ok_s && (dig_cnt_r == XCD_DIG_LAST);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dig_cnt_r <= XCD_DIG_CNT_RST;
      digital_cycle_o <= 1'b0;
    end else if (!xto_ok_s) begin
      dig_cnt_r <= XCD_DIG_CNT_RST;
      digital_cycle_o <= 1'b0;
    end else begin
      dig_cnt_r <= dig_cnt_r + 4'h1;
      digital_cycle_o <= dig_tick;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt_r <= XCD_BITCNT_RST;
      derived_bit_cycle_o <= 1'b0;
    end else if (!xto_ok_s) begin
      bit_cnt_r <= XCD_BITCNT_RST;
      derived_bit_cycle_o <= 1'b0;
    end else if (dig_tick) begin
      if (bit_cnt_r + 9'h001 >= bit_target) begin
        bit_cnt_r <= XCD_BITCNT_RST;
        derived_bit_cycle_o <= 1'b1;
      end else begin
        bit_cnt_r <= bit_cnt_r + 9'h001;
        derived_bit_cycle_o <= 1'b0;
      end
    end else begin
      derived_bit_cycle_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Tuning word and synthesizer divider
  // ---------------------------------------------------------------
  logic [XCD_WORD_W-1:0] tuning_nxt;
  logic [7:0] base2;

  assign tuning_nxt = {1'b0, tuning_part_low_i} + {1'b0, tuning_part_high_i};
  // Out-of-range words are passed on; keeping 3803 to 4053 is the host's job.
  always_comb begin
    if (!band_select_pin_i) begin
      base2 = XCD_BASE2_HIGH;
    end else if (band_select_bit_i) begin
      base2 = XCD_BASE2_LOW;
    end else begin
      base2 = XCD_BASE2_MID;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tuning_word_o <= XCD_WORD_RST;
      synth_divider_o <= XCD_DIVIDER_RST;
    end else begin
      tuning_word_o <= tuning_nxt;
      synth_divider_o <= (XCD_DIVIDER_W'(base2) << XCD_FRAC_SHIFT) +
                         XCD_DIVIDER_W'({tuning_nxt, 1'b0}) + XCD_FRAC_OFFSET2;
    end
  end

  // ---------------------------------------------------------------
  // Host reset, load capacitors and serial interface gate
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_reset_n_o <= 1'b0;
    end else if (!lower_ok_s || !xto_ok_s) begin
      host_reset_n_o <= 1'b0;
    end else if (upper_ok_s) begin
      host_reset_n_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_cap_reduce_o <= 1'b0;
      serial_if_enable_o <= 1'b0;
    end else begin
      load_cap_reduce_o <= idle_mode_i || sleep_mode_i;
      serial_if_enable_o <= lower_ok_s;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_host_clk_period: assert property (
    $rose(host_pos_r) ##0 host_run [*3] |=> $rose(host_pos_r)
  ) else $error("host clock period is not three cycles");

  a_host_clk_gate: assert property (
    !host_clk_enable_i [*2] |-> !host_pos_r
  ) else $error("host clock runs while disabled");

  a_low_supply_clk: assert property (
    !lower_ok_s [*2] |-> !host_pos_r && !serial_if_enable_o
  ) else $error("host clock or serial interface active at low supply");

  // Clocks since the last digital pulse; a long repetition would be costly to unroll.
  logic [4:0] dig_gap_r;
  logic dig_seen_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dig_gap_r <= 5'h00;
      dig_seen_r <= 1'b0;
    end else if (!xto_ok_s) begin
      dig_gap_r <= 5'h00;
      dig_seen_r <= 1'b0;
    end else if (digital_cycle_o) begin
      dig_gap_r <= 5'h01;
      dig_seen_r <= 1'b1;
    end else if (dig_gap_r != 5'h1f) begin
      dig_gap_r <= dig_gap_r + 5'h01;
    end
  end

  a_dig_period: assert property (
    digital_cycle_o && dig_seen_r |-> dig_gap_r == 5'(XCD_DIG_DIV)
  ) else $error("digital cycle is not sixteen clocks");

  a_dig_spacing: assert property (
    digital_cycle_o |=> !digital_cycle_o [*8]
  ) else $error("digital cycle pulses too close");

  a_div_hold: assert property (
    !xto_ok_s |=> dig_cnt_r == XCD_DIG_CNT_RST && host_cnt_r == XCD_HOST_CNT_RST
  ) else $error("dividers not held without oscillator-good");

  a_bit_on_tick: assert property (
    derived_bit_cycle_o |-> $past(dig_tick)
  ) else $error("bit cycle not aligned to digital cycle");

  a_range3_bit: assert property (
    baud_range_select_i == 2'h3 && bit_limit_factor_i == 6'h01 && dig_tick
      && $stable(baud_range_select_i) |=> derived_bit_cycle_o
  ) else $error("range three unit limit missed a bit cycle");

  a_tuning_sum: assert property (
    $stable(tuning_part_low_i) && $stable(tuning_part_high_i) |=>
      tuning_word_o == {1'b0, $past(tuning_part_low_i)} + {1'b0, $past(tuning_part_high_i)}
  ) else $error("tuning word is not the sum of its parts");

  a_reset_release: assert property (
    xto_ok_s && upper_ok_s && lower_ok_s |=> host_reset_n_o
  ) else $error("host reset not released");

  a_reset_hold: assert property (
    !xto_ok_s |=> !host_reset_n_o
  ) else $error("host reset released without oscillator-good");

  a_load_caps: assert property (
    (idle_mode_i || sleep_mode_i) |=> load_cap_reduce_o
  ) else $error("load capacitors not reduced in idle or sleep");

endmodule // xcd_top

/* bench/xcd_host_model.sv */
// Purpose: Host microcontroller model clocked from the block's host clock.
// Assumes: Only whole phases are measured; times are reported in ns.
// Notes: A cut first period after enabling is tolerated, never judged.
`timescale 1ns/1ps
module xcd_host_model (
  input wire logic host_clk_i, // Clock from the block.
  input wire logic host_reset_n_i, // Host reset from the block.
  output logic [31:0] high_ns_o, // Last whole high phase.
  output logic [31:0] low_ns_o, // Last whole low phase.
  output logic [31:0] rise_cnt_o // Rising edges seen, in reset or not.
);
  realtime t_rise = -1.0;
  realtime t_fall = -1.0;
  initial begin
    high_ns_o = 32'h0;
    low_ns_o = 32'h0;
    rise_cnt_o = 32'h0;
  end
  // A phase is reported only once both its edges were seen, so a short first one is harmless.
  // Rising edges are counted always, so a clock that runs while the host is held is still seen.
  always @(posedge host_clk_i) begin
    if (t_fall >= 0.0 && host_reset_n_i === 1'b1) low_ns_o <= 32'($rtoi($realtime - t_fall));
    t_rise = $realtime;
    rise_cnt_o <= rise_cnt_o + 32'h1;
  end
  always @(negedge host_clk_i) begin
    if (t_rise >= 0.0 && host_reset_n_i === 1'b1) high_ns_o <= 32'($rtoi($realtime - t_rise));
    t_fall = $realtime;
  end
endmodule // xcd_host_model

/* bench/xcd_top_tb.sv */
// Purpose: Self-checking bench for the clock divider and tuning block.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes: Status pins pass a synchroniser, so start-up waits allow a small window.
`timescale 1ns/1ps
module xcd_top_tb;
  import xcd_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk_i = 1'b0, resetn_i = 1'b0, xto_ok = 1'b0, up_ok = 1'b0, lo_ok = 1'b0;
  logic clk_en = 1'b0, idle = 1'b0, sleep = 1'b0, band_bit = 1'b0, band_pin = 1'b1;
  logic [1:0] range_sel = 2'h3;
  logic [5:0] factor = 6'h01;
  logic [12:0] part_lo = 13'h0000, part_hi = 13'h0000;
  logic host_clk, host_rst_n, dig, bit_cyc, load_cap, ser_en;
  logic [13:0] word;
  logic [21:0] divider;
  logic [31:0] high_ns, low_ns, rises;
  int errors = 0, n_tests = 0, ncyc = 0, dc_cnt = 0, dc_last = 0, dc_gap = 0;
  int bc_last = 0, bc_gap = 0;
  localparam int LIMIT = 10000;
  always #25 clk_i = ~clk_i;
  xcd_top xcd_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .xto_ok_i(xto_ok),
    .supply_output_upper_ok_i(up_ok), .supply_output_lower_ok_i(lo_ok),
    .host_clk_enable_i(clk_en), .idle_mode_i(idle), .sleep_mode_i(sleep),
    .baud_range_select_i(range_sel), .bit_limit_factor_i(factor),
    .tuning_part_low_i(part_lo), .tuning_part_high_i(part_hi),
    .band_select_bit_i(band_bit), .band_select_pin_i(band_pin), .host_clk_o(host_clk),
    .host_reset_n_o(host_rst_n), .digital_cycle_o(dig), .derived_bit_cycle_o(bit_cyc),
    .tuning_word_o(word), .synth_divider_o(divider), .load_cap_reduce_o(load_cap),
    .serial_if_enable_o(ser_en));
  xcd_host_model xcd_host_model_inst (.host_clk_i(host_clk), .host_reset_n_i(host_rst_n),
    .high_ns_o(high_ns), .low_ns_o(low_ns), .rise_cnt_o(rises));
  // ---------------------------------------------------------------
  // Pulse spacing monitor and hang limit
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    ncyc++;
    if (dig === 1'b1) begin
      dc_cnt++;
      dc_gap = ncyc - dc_last;
      dc_last = ncyc;
    end
    if (bit_cyc === 1'b1) begin
      bc_gap = ncyc - bc_last;
      bc_last = ncyc;
    end
    if (ncyc == LIMIT) begin
      errors++;
      $display("[FAIL] %0t run hung", $time);
      summarize();
    end
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_held();
    cyc(40);
    chk(host_rst_n, 0, "host reset released early");
    chk(dc_cnt, 0, "digital cycle ran without oscillator");
    chk(rises, 0, "host clock ran without oscillator");
  endtask
  task automatic t_xto_start();
    int s, r;
    @(posedge clk_i) xto_ok <= 1'b1;
    #1;
    s = ncyc;
    r = dc_cnt;
    while (dc_cnt == r && ncyc < s + 40) cyc(1);
    chk(ncyc - s >= 19 && ncyc - s <= 21, 1, "first digital cycle off");
    chk(host_rst_n, 1, "host reset not released");
    cyc(50);
    chk(dc_gap, 16, "digital cycle period");
  endtask
  task automatic t_host_clk();
    logic [31:0] r;
    cyc(30);
    chk(rises, 0, "host clock without enable");
    @(posedge clk_i) clk_en <= 1'b1;
    cyc(30);
    r = rises;
    cyc(30);
    chk(rises - r, 10, "host clock rate");
    chk(high_ns, 75, "host clock high time");
    chk(low_ns, 75, "host clock low time");
  endtask
  task automatic t_bits();
    logic [1:0] rg[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2};
    logic [5:0] fc[6] = '{6'h03, 6'h03, 6'h03, 6'h03, 6'h01, 6'h00};
    int p;
    for (int i = 0; i < 6; i++) begin
      p = 16 * ((fc[i] == 6'h00) ? 1 : int'(fc[i])) * (8 >> rg[i]);
      @(posedge clk_i) range_sel <= rg[i];
      factor <= fc[i];
      cyc(2 * p + 40);
      chk(bc_gap, p, "bit cycle period");
    end
  endtask
  task automatic t_tuning();
    logic [12:0] lo[4] = '{13'h0bb8, 13'h0fa0, 13'h1fff, 13'h0000};
    logic [12:0] hi[4] = '{13'h0323, 13'h0035, 13'h1fff, 13'h0000};
    logic [3:0] bd[4] = '{4'h3, 4'h1, 4'h0, 4'h2};
    logic [21:0] base2[4] = '{22'h31, 22'h81, 22'h81, 22'h41};
    logic [13:0] w;
    for (int i = 0; i < 4; i++) begin
      w = {1'b0, lo[i]} + {1'b0, hi[i]};
      @(posedge clk_i) part_lo <= lo[i];
      part_hi <= hi[i];
      band_bit <= bd[i][0];
      band_pin <= bd[i][1];
      cyc(3);
      chk(word, w, "tuning word");
      chk(divider, (base2[i] << 14) + {7'h0, w, 1'b0} + 22'h29, "synth divider");
    end
  endtask
  task automatic t_load_cap();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i) idle <= i[0];
      sleep <= i[1];
      cyc(3);
      chk(load_cap, i != 0, "load capacitor reduce");
    end
  endtask
  task automatic t_supply();
    logic [31:0] r;
    @(posedge clk_i) lo_ok <= 1'b0;
    up_ok <= 1'b0;
    cyc(6);
    r = rises;
    cyc(12);
    chk(rises - r, 0, "host clock ran on low supply");
    chk(host_clk, 0, "host clock not low");
    chk(ser_en, 0, "serial interface not ignored");
    chk(host_rst_n, 0, "host reset not asserted");
    @(posedge clk_i) lo_ok <= 1'b1;
    cyc(8);
    chk(ser_en, 1, "serial interface not back");
    chk(host_rst_n, 0, "host reset released below upper");
    @(posedge clk_i) up_ok <= 1'b1;
    cyc(6);
    chk(host_rst_n, 1, "host reset not released");
  endtask
  task automatic t_xto_drop();
    int r, h;
    @(posedge clk_i) xto_ok <= 1'b0;
    cyc(6);
    chk(host_rst_n, 0, "host reset kept on oscillator loss");
    r = dc_cnt;
    h = rises;
    cyc(40);
    chk(dc_cnt - r, 0, "digital cycle ran after loss");
    chk(rises - h, 0, "host clock ran after loss");
    t_xto_start();
  endtask
  initial begin
    cyc(20);
    @(posedge clk_i) resetn_i <= 1'b1;
    t_held();
    @(posedge clk_i) lo_ok <= 1'b1;
    up_ok <= 1'b1;
    t_xto_start();
    t_host_clk();
    t_bits();
    t_tuning();
    t_load_cap();
    t_supply();
    t_xto_drop();
    summarize();
  end
endmodule // xcd_top_tb
